// ===== verilog/fbmsi_pkg.sv
// Purpose: Constants for the fieldbus module status indication block
// Assumes: Single 20 MHz clock, plain register port
// Notes:   Register offsets are word indices on the register port
package fbmsi_pkg;
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned FLASH_HZ        = 2;
  localparam int unsigned FLICKER_HZ      = 10;
  localparam int unsigned TEST_STEP_MS    = 250;
  localparam int unsigned FLASH_DIV       = CLK_HZ / (2 * FLASH_HZ);
  localparam int unsigned FLICKER_DIV     = CLK_HZ / (2 * FLICKER_HZ);
  localparam int unsigned TEST_STEP_CYC   = CLK_HZ / 1000 * TEST_STEP_MS;

  localparam logic [3:0] ADDR_MODULE_TYPE = 4'h0;
  localparam logic [3:0] ADDR_FW_MAJMIN   = 4'h1;
  localparam logic [3:0] ADDR_LINE_SPEED  = 4'h2;
  localparam logic [3:0] ADDR_OP_STATE    = 4'h3;
  localparam logic [3:0] ADDR_FW_PATCH    = 4'h4;
  localparam logic [3:0] ADDR_NODE_ADDR   = 4'h5;
  localparam logic [3:0] ADDR_ACTIVE_NODE = 4'h6;
  localparam logic [3:0] ADDR_CONTROL     = 4'h7;
  localparam logic [3:0] ADDR_CHANNELS    = 4'h8;

  localparam logic [2:0] LINE_SPEED_RESET = 3'h0;
  localparam logic [2:0] LINE_SPEED_MAX   = 3'h4;
  localparam logic [15:0] MODULE_TYPE_MAX = 16'h01f3;
  localparam logic [15:0] FW_MAJMIN_MAX   = 16'h270f;
  localparam logic [6:0]  FW_PATCH_MAX    = 7'h63;
  localparam logic [3:0]  CHANNELS_DEF    = 4'h2;
  localparam logic [3:0]  CHANNELS_MAX    = 4'ha;
  localparam int unsigned CTRL_REINIT_BIT = 0;

  localparam logic [3:0] ST_SETUP     = 4'h0;
  localparam logic [3:0] ST_NET_INIT  = 4'h1;
  localparam logic [3:0] ST_PD_INACT  = 4'h2;
  localparam logic [3:0] ST_IDLE      = 4'h3;
  localparam logic [3:0] ST_ACTIVE    = 4'h4;
  localparam logic [3:0] ST_BUS_ERR   = 4'h5;
  localparam logic [3:0] ST_DB_LOAD   = 4'h6;
  localparam logic [3:0] ST_HOST_ERR  = 4'h7;
  localparam logic [3:0] ST_OPT_LOSS  = 4'h8;
  localparam logic [3:0] ST_SUPERVISE = 4'hc;

  // Indicator colour codes {red, green}; both on means yellow
  localparam logic [1:0] LED_OFF    = 2'h0;
  localparam logic [1:0] LED_GREEN  = 2'h1;
  localparam logic [1:0] LED_RED    = 2'h2;
  localparam logic [1:0] LED_YELLOW = 2'h3;

  typedef enum logic [3:0] {
    FBMSI_TEST_GREEN = 4'b0001,
    FBMSI_TEST_RED   = 4'b0010,
    FBMSI_TEST_OFF   = 4'b0100,
    FBMSI_TEST_DONE  = 4'b1000
  } fbmsi_test_e;
endpackage

// ===== verilog/fbmsi_top.sv
// Purpose: Status, indicator and parameter logic of a fieldbus option module
// Assumes: Status inputs are synchronous to clk_i
// Notes:   Overview of operation follows
// Overview of operation
// - Network indicator: off, green, green flash, red, red flash by state.
// - Both status indicators run a test sequence at startup first.
// - Module indicator: green normal, red major fault, red flash on IP conflict.
// - Port indicators: green 100M, yellow 10M, flicker on activity, off without link.
// - Read-only module type code limited to 0..499.
// - Firmware version in two read-only values, 0..9999 and 0..99.
// - Node address change takes effect only after re-initialisation.
// - Line speed selector accepts 0..4 with fixed speed/duplex encodings.
// - Two cyclic channels each way by default.
// - At most ten cyclic parameter data items.
// - Operating state codes 0 to 4 for setup through process active.
// - In network init, outgoing telegrams already carry mapped data.
// - State 5 on serious bus error, 6 while database loads.
// - Host error gives state 7, stops network, left only by restart.
// - State 8 when drive link is lost outside setup.
// - State 12 when supervised; reserved codes never reported.
// - Mapping or network error may force a drive trip.
`timescale 1ns/1ns
module fbmsi_top
  import fbmsi_pkg::*;
#(
  parameter int unsigned FLASH_CYC   = fbmsi_pkg::FLASH_DIV,
  parameter int unsigned FLICKER_CYC = fbmsi_pkg::FLICKER_DIV,
  parameter int unsigned TEST_CYC    = fbmsi_pkg::TEST_STEP_CYC,
  parameter logic [15:0] MODULE_TYPE = 16'h0064, // Arbitrary value
  parameter logic [15:0] FW_MAJMIN   = 16'h0065,
  parameter logic [6:0]  FW_PATCH    = 7'h00
)(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  input  wire logic        setup_done_i,
  input  wire logic        ip_valid_i,
  input  wire logic        net_ready_i,
  input  wire logic        pd_connected_i,
  input  wire logic        pd_running_i,
  input  wire logic        pd_timeout_i,
  input  wire logic        dup_ip_i,
  input  wire logic        event_a_i,
  input  wire logic        major_fault_state_i,
  input  wire logic        bus_error_i,
  input  wire logic        db_loading_i,
  input  wire logic        host_error_i,
  input  wire logic        drive_link_ok_i,
  input  wire logic        supervised_i,
  input  wire logic        map_error_i,
  input  wire logic [1:0]  port_link_i,
  input  wire logic [1:0]  port_speed100_i,
  input  wire logic [1:0]  port_activity_i,
  output logic [1:0]       net_led_o,
  output logic [1:0]       mod_led_o,
  output logic [3:0]       port_led_o,
  output logic [2:0]       line_speed_o,
  output logic [15:0]      node_addr_o,
  output logic             net_enable_o,
  output logic             tx_pd_enable_o,
  output logic             drive_trip_o
);
  import fbmsi_pkg::*;

  logic [2:0]  line_speed;
  logic [15:0] node_pending;
  logic [15:0] node_active;
  logic [3:0]  channels;
  logic [3:0]  op_state;
  logic [3:0]  next_op_state;
  logic        host_dead;
  logic        reinit;
  logic [31:0] flash_cnt;
  logic [31:0] flicker_cnt;
  logic [31:0] test_cnt;
  logic        flash;
  logic        flicker;
  fbmsi_test_e test_st;

  // Register decode
  wire wr_speed   = reg_wr_i && (reg_addr_i == ADDR_LINE_SPEED);
  wire wr_node    = reg_wr_i && (reg_addr_i == ADDR_NODE_ADDR);
  wire wr_ctrl    = reg_wr_i && (reg_addr_i == ADDR_CONTROL);
  wire wr_chan    = reg_wr_i && (reg_addr_i == ADDR_CHANNELS);
  wire speed_ok   = reg_wdata_i[2:0] <= LINE_SPEED_MAX && reg_wdata_i[31:3] == '0;
  wire chan_ok    = reg_wdata_i[3:0] <= CHANNELS_MAX && reg_wdata_i[31:4] == '0;
  wire reinit_req = wr_ctrl && reg_wdata_i[CTRL_REINIT_BIT];
  // Clamps guard against out-of-range build parameters
  wire [15:0] type_val   =
    (MODULE_TYPE > MODULE_TYPE_MAX) ? MODULE_TYPE_MAX : MODULE_TYPE;
  wire [15:0] majmin_val = (FW_MAJMIN > FW_MAJMIN_MAX) ? FW_MAJMIN_MAX : FW_MAJMIN;
  wire [6:0]  patch_val  = (FW_PATCH > FW_PATCH_MAX) ? FW_PATCH_MAX : FW_PATCH;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      line_speed   <= LINE_SPEED_RESET;
      node_pending <= '0;
      node_active  <= '0;
      channels     <= CHANNELS_DEF;
      reinit       <= 1'b0;
    end
    else
    begin
      if (wr_speed && speed_ok)
        line_speed <= reg_wdata_i[2:0];
      if (wr_node)
        node_pending <= reg_wdata_i[15:0];
      if (wr_chan && chan_ok)
        channels <= reg_wdata_i[3:0];
      reinit <= reinit_req;
      if (reinit)
        node_active <= node_pending;
    end
  end

  // Read data valid exactly one cycle after the strobe
  logic [31:0] rd_mux;
  always_comb
  begin
    case (reg_addr_i)
      ADDR_MODULE_TYPE: rd_mux = {16'h0000, type_val};
      ADDR_FW_MAJMIN:   rd_mux = {16'h0000, majmin_val};
      ADDR_LINE_SPEED:  rd_mux = {29'h0, line_speed};
      ADDR_OP_STATE:    rd_mux = {28'h0, op_state};
      ADDR_FW_PATCH:    rd_mux = {25'h0, patch_val};
      ADDR_NODE_ADDR:   rd_mux = {16'h0000, node_pending};
      ADDR_ACTIVE_NODE: rd_mux = {16'h0000, node_active};
      ADDR_CHANNELS:    rd_mux = {28'h0, channels};
      default:          rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 32'h0;
    else if (reg_rd_i)
      reg_rdata_o <= rd_mux;
    else
      reg_rdata_o <= 32'h0;
  end

  // Operating state; priority: host error, drive loss, database, bus error
  always_comb
  begin
    next_op_state = op_state;
    if (host_dead || host_error_i)
      next_op_state = ST_HOST_ERR;
    else if (reinit)
      next_op_state = ST_SETUP;
    else if (!drive_link_ok_i && op_state != ST_SETUP)
      next_op_state = ST_OPT_LOSS;
    else if (db_loading_i)
      next_op_state = ST_DB_LOAD;
    else if (op_state == ST_SETUP)
      next_op_state = setup_done_i ? ST_NET_INIT : ST_SETUP;
    else if (op_state == ST_NET_INIT && !net_ready_i)
      next_op_state = ST_NET_INIT;
    else if (bus_error_i)
      next_op_state = ST_BUS_ERR;
    else if (supervised_i)
      next_op_state = ST_SUPERVISE;
    else if (pd_running_i)
      next_op_state = ST_ACTIVE;
    else if (pd_connected_i)
      next_op_state = ST_IDLE;
    else
      next_op_state = ST_PD_INACT;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      op_state  <= ST_SETUP;
      host_dead <= 1'b0;
    end
    else
    begin
      op_state <= next_op_state;
      if (host_error_i)
        host_dead <= 1'b1;
    end
  end

  assign net_enable_o   = !host_dead && op_state != ST_HOST_ERR;
  assign tx_pd_enable_o = net_enable_o && op_state != ST_SETUP;
  assign line_speed_o   = line_speed;
  assign node_addr_o    = node_active;

  // Dividers; counters sized wide so large parameters fit
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      flash_cnt   <= '0;
      flicker_cnt <= '0;
      flash       <= 1'b0;
      flicker     <= 1'b0;
    end
    else
    begin
      flash_cnt   <= (flash_cnt >= FLASH_CYC - 1) ? '0 : flash_cnt + 32'd1;
      flicker_cnt <= (flicker_cnt >= FLICKER_CYC - 1) ? '0 : flicker_cnt + 32'd1;
      if (flash_cnt >= FLASH_CYC - 1)
        flash <= ~flash;
      if (flicker_cnt >= FLICKER_CYC - 1)
        flicker <= ~flicker;
    end
  end

  // Startup lamp test: green, red, off, then normal display
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      test_st  <= FBMSI_TEST_GREEN;
      test_cnt <= '0;
    end
    else if (test_st != FBMSI_TEST_DONE)
    begin
      if (test_cnt >= TEST_CYC - 1)
      begin
        test_cnt <= '0;
        case (test_st)
          FBMSI_TEST_GREEN: test_st <= FBMSI_TEST_RED;
          FBMSI_TEST_RED:   test_st <= FBMSI_TEST_OFF;
          FBMSI_TEST_OFF:   test_st <= FBMSI_TEST_DONE;
          default:          test_st <= FBMSI_TEST_DONE;
        endcase
      end
      else
        test_cnt <= test_cnt + 32'd1;
    end
  end

  logic [1:0] test_led;
  always_comb
  begin
    case (test_st)
      FBMSI_TEST_GREEN: test_led = LED_GREEN;
      FBMSI_TEST_RED:   test_led = LED_RED;
      FBMSI_TEST_OFF:   test_led = LED_OFF;
      default:          test_led = LED_OFF;
    endcase
  end

  // Network indicator; red causes outrank green
  logic [1:0] net_norm;
  always_comb
  begin
    if (!ip_valid_i)
      net_norm = LED_OFF;
    else if (dup_ip_i || event_a_i)
      net_norm = LED_RED;
    else if (pd_timeout_i)
      net_norm = flash ? LED_RED : LED_OFF;
    else if (op_state == ST_ACTIVE || op_state == ST_IDLE)
      net_norm = LED_GREEN;
    else
      net_norm = flash ? LED_GREEN : LED_OFF;
  end

  logic [1:0] mod_norm;
  always_comb
  begin
    if (major_fault_state_i || event_a_i)
      mod_norm = LED_RED;
    else if (dup_ip_i)
      mod_norm = flash ? LED_RED : LED_OFF;
    else
      mod_norm = LED_GREEN;
  end

  wire testing = test_st != FBMSI_TEST_DONE;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      net_led_o <= LED_OFF;
      mod_led_o <= LED_OFF;
    end
    else
    begin
      net_led_o <= testing ? test_led : net_norm;
      mod_led_o <= testing ? test_led : mod_norm;
    end
  end

  // Per-port link and activity indicators
  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      wire [1:0] colour = port_speed100_i[p] ? LED_GREEN : LED_YELLOW;
      wire [1:0] shown  = !port_link_i[p] ? LED_OFF :
                          (port_activity_i[p] && flicker) ? LED_OFF : colour;
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
          port_led_o[2*p+1:2*p] <= LED_OFF;
        else
          port_led_o[2*p+1:2*p] <= shown;
      end
    end
  endgenerate

  // Trip is a level while a mapping or network fault stands
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      drive_trip_o <= 1'b0;
    else
      drive_trip_o <= map_error_i || op_state == ST_BUS_ERR;
  end
endmodule

// ===== dv/fbmsi_props.sv
// Purpose: Port-level properties of the status indication block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ns
module fbmsi_props
  import fbmsi_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        host_error_i,
  input wire logic        map_error_i,
  input wire logic [1:0]  port_link_i,
  input wire logic [1:0]  net_led_o,
  input wire logic [1:0]  mod_led_o,
  input wire logic [3:0]  port_led_o,
  input wire logic [2:0]  line_speed_o,
  input wire logic [15:0] node_addr_o,
  input wire logic        net_enable_o,
  input wire logic        drive_trip_o
);
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_NO_RESERVED: assert property (
    reg_rd_i && reg_addr_i == ADDR_OP_STATE |=> !(reg_rdata_o inside {32'h9, 32'ha, 32'hb,
    32'hd, 32'he}) && reg_rdata_o < 32'hf) else $error("reserved state code read");
  AST_SPEED_RANGE: assert property (line_speed_o <= 3'h4)
    else $error("line speed out of range");
  AST_SPEED_WRITE: assert property (
    reg_wr_i && reg_addr_i == ADDR_LINE_SPEED && reg_wdata_i <= 32'h4
    |=> line_speed_o == $past(reg_wdata_i[2:0])) else $error("line speed write lost");
  AST_SPEED_REFUSE: assert property (
    reg_wr_i && reg_addr_i == ADDR_LINE_SPEED && reg_wdata_i > 32'h4
    |=> $stable(line_speed_o)) else $error("bad line speed taken");
  // Guard against a reinit still in flight from an earlier write
  AST_NODE_HOLD: assert property (
    reg_wr_i && reg_addr_i == ADDR_NODE_ADDR && !$past(reg_wr_i) && !$past(reg_wr_i, 2)
    |=> $stable(node_addr_o) [*2]) else $error("node address changed without reinit");
  AST_TRIP: assert property (map_error_i |=> drive_trip_o)
    else $error("no trip on mapping error");
  AST_HOST_STOP: assert property (host_error_i |=> !net_enable_o)
    else $error("network still enabled on host error");
  AST_HOST_LATCH: assert property (!net_enable_o |=> !net_enable_o)
    else $error("host error state left without restart");
  AST_STARTUP: assert property (
    $fell(sys_rst_i) |-> ##[1:3] (net_led_o == LED_GREEN && mod_led_o == LED_GREEN))
    else $error("no indicator test after reset");
  AST_PORT_OFF: assert property (!port_link_i[1] |=> port_led_o[3:2] == LED_OFF)
    else $error("port indicator lit without link");
endmodule

bind fbmsi_top fbmsi_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .host_error_i(host_error_i),
  .map_error_i(map_error_i), .port_link_i(port_link_i), .net_led_o(net_led_o),
  .mod_led_o(mod_led_o), .port_led_o(port_led_o), .line_speed_o(line_speed_o),
  .node_addr_o(node_addr_o), .net_enable_o(net_enable_o), .drive_trip_o(drive_trip_o));

// ===== dv/fbmsi_far_model.sv
// Purpose: Ethernet ports and host drive link seen from the module
// Assumes: Commands from the bench change after a clock edge
// Notes:   Frames alternate every cycle while traffic is on
`timescale 1ns/1ns
module fbmsi_far_model (
  input  wire logic       clk_i,
  input  wire logic       net_enable_i,
  input  wire logic [1:0] link_up_i,
  input  wire logic [1:0] fast_i,
  input  wire logic [1:0] traffic_i,
  input  wire logic       drop_drive_i,
  output logic [1:0]      port_link_o,
  output logic [1:0]      port_speed100_o,
  output logic [1:0]      port_activity_o,
  output logic            drive_link_ok_o
);
  logic [1:0] pulse = 2'h0;
  always_ff @(posedge clk_i)
  begin
    pulse <= ~pulse;
  end
  // No frames without a link or once the module has left the network
  assign port_activity_o = traffic_i & link_up_i & pulse & {2{net_enable_i}};
  assign port_link_o = link_up_i;
  assign port_speed100_o = fast_i & link_up_i;
  assign drive_link_ok_o = !drop_drive_i;
endmodule

// ===== dv/fbmsi_top_tb.sv
// Purpose: Self-checking bench for the status indication block
// Assumes: Short divider and test step parameters
// Notes:   Module type and firmware major/minor use out-of-range values; patch keeps its default 0
`timescale 1ns/1ns
module fbmsi_top_tb;
  import fbmsi_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  stat = 8'h00;
  logic [6:0]  flg = 7'h00;
  logic [1:0]  link_up = 2'h0, fast = 2'h0, traffic = 2'h0;
  logic [31:0] reg_rdata_o, rd;
  logic [1:0]  net_led_o, mod_led_o, plink, pfast, pact;
  logic [3:0]  port_led_o;
  logic [2:0]  line_speed_o;
  logic [15:0] node_addr_o;
  logic        net_enable_o, tx_pd_enable_o, drive_trip_o, dlink;
  int          fails = 0;
  int          checks = 0;

  fbmsi_top #(.FLASH_CYC(4), .FLICKER_CYC(2), .TEST_CYC(8), .MODULE_TYPE(16'h0258),
    .FW_MAJMIN(16'h2710)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .setup_done_i(stat[7]), .ip_valid_i(flg[6]), .net_ready_i(stat[6]),
    .pd_connected_i(stat[5]), .pd_running_i(stat[4]), .pd_timeout_i(flg[5]),
    .dup_ip_i(flg[4]), .event_a_i(flg[3]), .major_fault_state_i(flg[2]),
    .bus_error_i(stat[2]), .db_loading_i(stat[1]), .host_error_i(flg[1]),
    .drive_link_ok_i(dlink), .supervised_i(stat[3]), .map_error_i(flg[0]),
    .port_link_i(plink), .port_speed100_i(pfast), .port_activity_i(pact),
    .net_led_o(net_led_o), .mod_led_o(mod_led_o), .port_led_o(port_led_o),
    .line_speed_o(line_speed_o), .node_addr_o(node_addr_o), .net_enable_o(net_enable_o),
    .tx_pd_enable_o(tx_pd_enable_o), .drive_trip_o(drive_trip_o));

  fbmsi_far_model far (.clk_i(clk_i), .net_enable_i(net_enable_o), .link_up_i(link_up),
    .fast_i(fast), .traffic_i(traffic), .drop_drive_i(stat[0]), .port_link_o(plink),
    .port_speed100_o(pfast), .port_activity_o(pact), .drive_link_ok_o(dlink));

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd_check(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, e);
  endtask

  task automatic do_reset();
    sys_rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask

  // Samples a window long enough for several flash periods
  task automatic expect_led(input int sel, input logic [1:0] col, input bit flash);
    logic [1:0] v;
    bit         on, off, other;
    on = 0;
    off = 0;
    other = 0;
    idle(3);
    repeat (24)
    begin
      idle(1);
      v = sel == 0 ? net_led_o : sel == 1 ? mod_led_o : sel == 2 ? port_led_o[1:0] :
          port_led_o[3:2];
      on |= v === col;
      off |= v === LED_OFF && col !== LED_OFF;
      other |= v !== col && v !== LED_OFF;
    end
    check({on, off, other}, {1'b1, flash, 1'b0});
  endtask

  task automatic test_startup();
    idle(4);
    check({net_led_o, mod_led_o}, {LED_GREEN, LED_GREEN});
    idle(8);
    check({net_led_o, mod_led_o}, {LED_RED, LED_RED});
    idle(8);
    check({net_led_o, mod_led_o}, {LED_OFF, LED_OFF});
    rd_check(ADDR_OP_STATE, 32'h0);
    $display("test_startup done");
  endtask

  task automatic test_regs();
    rd_check(ADDR_MODULE_TYPE, 32'h1f3);
    // Read data must stand for one cycle only
    idle(1);
    check(reg_rdata_o, 32'h0);
    rd_check(ADDR_FW_MAJMIN, 32'h270f);
    rd_check(ADDR_FW_PATCH, 32'h0);
    rd_check(ADDR_LINE_SPEED, 32'h0);
    rd_check(ADDR_CHANNELS, 32'h2);
    reg_write(ADDR_CHANNELS, 32'ha);
    rd_check(ADDR_CHANNELS, 32'ha);
    reg_write(ADDR_CHANNELS, 32'hb);
    rd_check(ADDR_CHANNELS, 32'ha);
    reg_write(ADDR_MODULE_TYPE, 32'h5);
    rd_check(ADDR_MODULE_TYPE, 32'h1f3);
    reg_write(4'hf, 32'h3);
    rd_check(4'hf, 32'h0);
    $display("test_regs done");
  endtask

  task automatic test_line_speed();
    for (int v = 0; v <= 6; v++)
    begin
      reg_write(ADDR_LINE_SPEED, 32'(v));
      rd_check(ADDR_LINE_SPEED, v > 4 ? 32'h4 : 32'(v));
      check(32'(line_speed_o), v > 4 ? 32'h4 : 32'(v));
    end
    reg_write(ADDR_LINE_SPEED, 32'h0);
    $display("test_line_speed done");
  endtask

  task automatic test_node();
    reg_write(ADDR_NODE_ADDR, 32'h1234);
    reg_write(ADDR_CONTROL, 32'h1);
    idle(3);
    check(32'(node_addr_o), 32'h1234);
    reg_write(ADDR_NODE_ADDR, 32'h00a5);
    idle(3);
    check(32'(node_addr_o), 32'h1234);
    rd_check(ADDR_ACTIVE_NODE, 32'h1234);
    reg_write(ADDR_CONTROL, 32'h1);
    idle(3);
    check(32'(node_addr_o), 32'h00a5);
    $display("test_node done");
  endtask

  task automatic test_states();
    logic [7:0] vec [10] = '{8'h00, 8'h80, 8'hc0, 8'he0, 8'hf0, 8'hf8, 8'hf4, 8'hf2, 8'hf1,
                             8'hf0};
    logic [3:0] exp [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hc, 4'h5, 4'h6, 4'h8, 4'h4};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_i);
      stat <= vec[i];
      idle(4);
      rd_check(ADDR_OP_STATE, {28'h0, exp[i]});
      if (i == 1)
        check(tx_pd_enable_o, 1'b1);
      if (i == 6)
        check(drive_trip_o, 1'b1);
    end
    @(posedge clk_i);
    flg <= 7'h01;
    idle(3);
    check(drive_trip_o, 1'b1);
    @(posedge clk_i);
    flg <= 7'h02;
    idle(3);
    @(posedge clk_i);
    flg <= 7'h00;
    idle(3);
    rd_check(ADDR_OP_STATE, 32'h7);
    check(net_enable_o, 1'b0);
    @(posedge clk_i);
    stat <= 8'h00;
    do_reset();
    idle(2);
    check(net_enable_o, 1'b1);
    rd_check(ADDR_OP_STATE, 32'h0);
    $display("test_states done");
  endtask

  task automatic test_leds();
    logic [5:0] tbl [6] = '{6'b01_0_01_0, 6'b01_0_01_0, 6'b10_1_01_0, 6'b10_0_10_1,
                            6'b10_0_10_0, 6'b01_0_10_0};
    logic [6:0] fv [6] = '{7'h00, 7'h40, 7'h60, 7'h50, 7'h48, 7'h44};
    idle(30);
    expect_led(0, LED_OFF, 0);
    @(posedge clk_i);
    flg <= 7'h40;
    expect_led(0, LED_GREEN, 1);
    @(posedge clk_i);
    stat <= 8'hf0;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_i);
      flg <= fv[i];
      expect_led(0, i == 0 ? LED_OFF : tbl[i][5:4], tbl[i][3]);
      expect_led(1, tbl[i][2:1], tbl[i][0]);
    end
    @(posedge clk_i);
    link_up <= 2'b01;
    fast <= 2'b01;
    expect_led(2, LED_GREEN, 0);
    @(posedge clk_i);
    traffic <= 2'b11;
    expect_led(2, LED_GREEN, 1);
    @(posedge clk_i);
    fast <= 2'b00;
    expect_led(2, LED_YELLOW, 1);
    @(posedge clk_i);
    traffic <= 2'b00;
    expect_led(2, LED_YELLOW, 0);
    @(posedge clk_i);
    link_up <= 2'b00;
    expect_led(2, LED_OFF, 0);
    // Second port on its own so its indicator bits are exercised too
    @(posedge clk_i);
    link_up <= 2'b10;
    fast <= 2'b10;
    expect_led(3, LED_GREEN, 0);
    @(posedge clk_i);
    fast <= 2'b00;
    traffic <= 2'b10;
    expect_led(3, LED_YELLOW, 1);
    @(posedge clk_i);
    link_up <= 2'b00;
    traffic <= 2'b00;
    expect_led(3, LED_OFF, 0);
    $display("test_leds done");
  endtask

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk_i);
    $display("[FAIL] %0t watchdog expired", $time);
    fails++;
    complete_run();
  end

  initial
  begin
    do_reset();
    test_startup();
    test_regs();
    test_line_speed();
    test_node();
    test_states();
    test_leds();
    complete_run();
  end
endmodule
